// ==== hw/sdf_fifo_top.sv ====
// The placing of the registers and the APB register port were left to the implementer.

`include "sdf_consts.svh"

`default_nettype none

module sdf_fifo_top #(
	parameter int WR_WIDTH = 8,
	parameter int RD_WIDTH = 8,
	parameter int DEPTH = 16,
	parameter bit DUAL_CLOCK = 1'b0,
	parameter bit EXTRA_BIT = 1'b1,
	parameter int ALMOST_FULL_LVL = DEPTH - 2,
	parameter int ALMOST_EMPTY_LVL = 2,
	localparam int AW = $clog2(DEPTH),
	localparam int PW = AW + 1
) (
	input wire logic CLK_SYS_IN,
	input wire logic RST_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [`SDF_APB_AW-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	output logic IRQ_OUT,
	input wire logic WR_REQ_IN,
	input wire logic [WR_WIDTH-1:0] WR_DATA_IN,
	input wire logic RD_REQ_IN,
	output logic [RD_WIDTH-1:0] RD_DATA_OUT,
	output logic FULL_OUT,
	output logic EMPTY_OUT,
	output logic ALMOST_FULL_OUT,
	output logic ALMOST_EMPTY_OUT,
	output logic [PW-1:0] USED_OUT,
	output logic [PW-1:0] WR_USED_OUT,
	output logic [PW-1:0] RD_USED_OUT
);
	// ------------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic rst_n;

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_reg[1];

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [DEPTH-1:0][WR_WIDTH-1:0] mem;
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [WR_WIDTH-1:0] rd_data;
		logic full_seen;
		logic empty_seen;
		sdf_pkg::sdf_ctrl_s ctrl;
		sdf_pkg::sdf_irq_s irq_stat;
		sdf_pkg::sdf_irq_s irq_mask;
		sdf_pkg::sdf_word_t prdata;
		logic pslverr;
	} sdf_top_s;

	sdf_top_s s_reg, s_next;
	logic [PW-1:0] count;
	logic sc_full;
	logic sc_empty;
	logic fifo_full;
	logic fifo_empty;
	logic wr_accept;
	logic rd_accept;
	logic apb_wr;
	logic mode_hold;
	logic dc_full;
	logic dc_empty;
	logic [PW-1:0] dc_wr_used;
	logic [PW-1:0] dc_rd_used;
	logic [RD_WIDTH-1:0] dc_data;

	// ------------------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------------------
	function automatic logic reg_hit(input logic [`SDF_APB_AW-1:0] a);
		return (a == `SDF_OFF_CTRL) || (a == `SDF_OFF_STATUS) ||
			(a == `SDF_OFF_IRQ_STAT) || (a == `SDF_OFF_IRQ_MASK);
	endfunction

	// ------------------------------------------------------------------------
	// Variant selection
	// ------------------------------------------------------------------------
	// Both ends of the dual variant run on the system clock here; the core
	// itself makes no assumption about how the two clocks relate.
	if (DUAL_CLOCK) begin : g_dual
		sdf_dual_core #(
			.WR_WIDTH(WR_WIDTH),
			.RD_WIDTH(RD_WIDTH),
			.DEPTH(DEPTH),
			.EXTRA_BIT(EXTRA_BIT)
		) u_dual (
			.wr_clk_in(CLK_SYS_IN),
			.wr_rst_n_in(rst_n),
			.wr_req_in(WR_REQ_IN),
			.wr_data_in(WR_DATA_IN),
			.ovf_prot_in(s_reg.ctrl.ovf_prot),
			.wr_full_out(dc_full),
			.wr_used_out(dc_wr_used),
			.rd_clk_in(CLK_SYS_IN),
			.rd_rst_n_in(rst_n),
			.rd_req_in(RD_REQ_IN),
			.show_ahead_in(s_reg.ctrl.show_ahead),
			.unf_prot_in(s_reg.ctrl.unf_prot),
			.rd_data_out(dc_data),
			.rd_empty_out(dc_empty),
			.rd_used_out(dc_rd_used)
		);
	end else begin : g_single
		assign dc_full = 1'b0;
		assign dc_empty = 1'b1;
		assign dc_wr_used = '0;
		assign dc_rd_used = '0;
		assign dc_data = '0;
	end

	if (!DUAL_CLOCK && (WR_WIDTH != RD_WIDTH)) begin : g_width_error
		$error("single-clock buffer needs equal write and read widths");
	end

	// ------------------------------------------------------------------------
	// Single-clock buffer
	// ------------------------------------------------------------------------
	// The count is the pointer difference with one spare bit, so a depth that
	// is a power of two makes the wrap free.
	assign count = s_reg.wr_ptr - s_reg.rd_ptr;
	assign sc_full = count == PW'(DEPTH);
	assign sc_empty = count == '0;
	assign fifo_full = DUAL_CLOCK ? dc_full : sc_full;
	assign fifo_empty = DUAL_CLOCK ? dc_empty : sc_empty;
	assign wr_accept = WR_REQ_IN && (!fifo_full || !s_reg.ctrl.ovf_prot);
	assign rd_accept = RD_REQ_IN && (!fifo_empty || !s_reg.ctrl.unf_prot);
	assign apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
	assign mode_hold = s_next.ctrl.show_ahead == s_reg.ctrl.show_ahead;

	always_comb begin
		logic [PW-1:0] rd_nx;
		sdf_pkg::sdf_irq_s ev;
		sdf_pkg::sdf_irq_s clr;
		sdf_pkg::sdf_word_t status;
		rd_nx = s_reg.rd_ptr;
		ev = '0;
		clr = '0;
		status = '0;
		s_next = s_reg;
		if (!DUAL_CLOCK) begin
			if (wr_accept) begin
				s_next.mem[s_reg.wr_ptr[AW-1:0]] = WR_DATA_IN;
				s_next.wr_ptr = s_reg.wr_ptr + PW'(1);
			end
			if (rd_accept) begin
				rd_nx = s_reg.rd_ptr + PW'(1);
			end
			s_next.rd_ptr = rd_nx;
			if (s_reg.ctrl.show_ahead) begin
				// A word written into the shown slot is forwarded straight
				// from the input, since the array only holds it after the edge.
				if (wr_accept && (s_reg.wr_ptr[AW-1:0] == rd_nx[AW-1:0])) begin
					s_next.rd_data = WR_DATA_IN;
				end else begin
					s_next.rd_data = s_reg.mem[rd_nx[AW-1:0]];
				end
			end else if (rd_accept) begin
				s_next.rd_data = s_reg.mem[s_reg.rd_ptr[AW-1:0]];
			end
		end
		s_next.full_seen = fifo_full;
		s_next.empty_seen = fifo_empty;
		ev.full_hit = fifo_full && !s_reg.full_seen;
		ev.empty_hit = fifo_empty && !s_reg.empty_seen;
		ev.overflow_try = WR_REQ_IN && fifo_full;
		ev.underflow_try = RD_REQ_IN && fifo_empty;
		if (apb_wr && (PADDR_IN == `SDF_OFF_CTRL)) begin
			s_next.ctrl = sdf_pkg::sdf_ctrl_s'(PWDATA_IN[`SDF_CTRL_W-1:0]);
		end
		if (apb_wr && (PADDR_IN == `SDF_OFF_IRQ_MASK)) begin
			s_next.irq_mask = sdf_pkg::sdf_irq_s'(PWDATA_IN[`SDF_IRQ_W-1:0]);
		end
		if (apb_wr && (PADDR_IN == `SDF_OFF_IRQ_STAT)) begin
			clr = sdf_pkg::sdf_irq_s'(PWDATA_IN[`SDF_IRQ_W-1:0]);
		end
		// An event in the clearing cycle survives the clear.
		s_next.irq_stat = (s_reg.irq_stat & ~clr) | ev;
		status[`SDF_ST_FULL] = fifo_full;
		status[`SDF_ST_EMPTY] = fifo_empty;
		status[`SDF_ST_AFULL] = ALMOST_FULL_OUT;
		status[`SDF_ST_AEMPTY] = ALMOST_EMPTY_OUT;
		status[`SDF_ST_CNT_LSB +: PW] = DUAL_CLOCK ? RD_USED_OUT : USED_OUT;
		status[`SDF_ST_WCNT_LSB +: PW] = WR_USED_OUT;
		// Read data is captured in the setup phase so that it comes from a
		// register while the slave still answers without wait states.
		if (PSEL_IN && !PENABLE_IN) begin
			s_next.pslverr = !reg_hit(PADDR_IN);
			case (PADDR_IN)
				`SDF_OFF_CTRL: s_next.prdata = 32'(s_reg.ctrl);
				`SDF_OFF_STATUS: s_next.prdata = status;
				`SDF_OFF_IRQ_STAT: s_next.prdata = 32'(s_reg.irq_stat);
				`SDF_OFF_IRQ_MASK: s_next.prdata = 32'(s_reg.irq_mask);
				default: s_next.prdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.empty_seen <= 1'b1;
			s_reg.ctrl <= `SDF_CTRL_RST;
			s_reg.irq_mask <= `SDF_IRQ_MASK_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign PRDATA_OUT = s_reg.prdata;
	assign PREADY_OUT = PSEL_IN && PENABLE_IN;
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && s_reg.pslverr;
	assign IRQ_OUT = |(s_reg.irq_stat & s_reg.irq_mask);
	assign RD_DATA_OUT = DUAL_CLOCK ? dc_data : RD_WIDTH'(s_reg.rd_data);
	assign FULL_OUT = fifo_full;
	assign EMPTY_OUT = fifo_empty;
	assign ALMOST_FULL_OUT = !DUAL_CLOCK && (count >= PW'(ALMOST_FULL_LVL));
	assign ALMOST_EMPTY_OUT = !DUAL_CLOCK && (count < PW'(ALMOST_EMPTY_LVL));
	assign USED_OUT = DUAL_CLOCK ? '0 : (EXTRA_BIT ? count : {1'b0, count[AW-1:0]});
	assign WR_USED_OUT = dc_wr_used;
	assign RD_USED_OUT = dc_rd_used;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_IN);
	endclocking

	default disable iff (!rst_n);

	chk_legacy_fetch: assert property (
		!DUAL_CLOCK && !s_reg.ctrl.show_ahead && mode_hold && rd_accept
		|=> RD_DATA_OUT == RD_WIDTH'($past(s_reg.mem[s_reg.rd_ptr[AW-1:0]])))
		else $error("legacy fetch did not show the requested word");

	chk_legacy_hold: assert property (
		!DUAL_CLOCK && !s_reg.ctrl.show_ahead && mode_hold && !rd_accept
		|=> $stable(RD_DATA_OUT))
		else $error("legacy output changed without a request");

	chk_show_oldest: assert property (
		!DUAL_CLOCK && s_reg.ctrl.show_ahead && $past(s_reg.ctrl.show_ahead)
		|-> RD_DATA_OUT == RD_WIDTH'(s_reg.mem[s_reg.rd_ptr[AW-1:0]]))
		else $error("show-ahead output is not the oldest word");

	chk_ack_advance: assert property (
		!DUAL_CLOCK && s_reg.ctrl.show_ahead && RD_REQ_IN && !EMPTY_OUT
		|=> s_reg.rd_ptr == $past(s_reg.rd_ptr) + PW'(1))
		else $error("acknowledge did not advance the read side");

	chk_ovf_guard: assert property (
		!DUAL_CLOCK && s_reg.ctrl.ovf_prot && FULL_OUT && WR_REQ_IN
		|=> $stable(s_reg.wr_ptr) && $stable(s_reg.mem))
		else $error("write taken while full and protected");

	chk_unf_guard: assert property (
		!DUAL_CLOCK && s_reg.ctrl.unf_prot && EMPTY_OUT && RD_REQ_IN && !WR_REQ_IN && mode_hold
		|=> $stable(s_reg.rd_ptr) && $stable(RD_DATA_OUT))
		else $error("read taken while empty and protected");

	chk_rw_same_edge: assert property (
		!DUAL_CLOCK && wr_accept && rd_accept
		|=> USED_OUT == $past(USED_OUT) && s_reg.wr_ptr == $past(s_reg.wr_ptr) + PW'(1))
		else $error("simultaneous write and read lost an operation");

	chk_count_full: assert property (
		!DUAL_CLOCK && FULL_OUT |-> USED_OUT == (EXTRA_BIT ? PW'(DEPTH) : PW'(0)))
		else $error("fill count wrong while full");

	chk_full_rise: assert property (
		!DUAL_CLOCK && s_reg.ctrl.ovf_prot && $rose(FULL_OUT) |-> $past(count) == PW'(DEPTH - 1))
		else $error("full rose away from the capacity edge");

	chk_empty_rise: assert property (
		!DUAL_CLOCK && s_reg.ctrl.unf_prot && $rose(EMPTY_OUT) |-> $past(count) == PW'(1))
		else $error("empty rose away from the zero edge");

	chk_reset_empty: assert property (
		$rose(rst_n) |-> EMPTY_OUT && !FULL_OUT && USED_OUT == '0 && WR_USED_OUT == '0)
		else $error("buffer not empty after reset");

	chk_irq_sticky: assert property (
		s_reg.irq_stat.full_hit && !(apb_wr && (PADDR_IN == `SDF_OFF_IRQ_STAT))
		|=> s_reg.irq_stat.full_hit)
		else $error("status bit dropped without a clear");

	cov_full_reached: cover property (FULL_OUT && WR_REQ_IN);
	cov_rw_same: cover property (wr_accept && rd_accept && !EMPTY_OUT);
	cov_show_ack: cover property (s_reg.ctrl.show_ahead && rd_accept ##1 rd_accept);
	cov_irq_raised: cover property (IRQ_OUT);
endmodule // sdf_fifo_top

`default_nettype wire

// ==== inc/sdf_consts.svh ====
`ifndef SDF_CONSTS_SVH
`define SDF_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SDF_APB_AW 8
`define SDF_OFF_CTRL 8'h00
`define SDF_OFF_STATUS 8'h04
`define SDF_OFF_IRQ_STAT 8'h08
`define SDF_OFF_IRQ_MASK 8'h0c

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define SDF_CTRL_W 3
`define SDF_IRQ_W 4
`define SDF_ST_FULL 0
`define SDF_ST_EMPTY 1
`define SDF_ST_AFULL 2
`define SDF_ST_AEMPTY 3
`define SDF_ST_CNT_LSB 8
`define SDF_ST_WCNT_LSB 20

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SDF_CTRL_RST 3'h6
`define SDF_IRQ_MASK_RST 4'h0

`endif

// ==== inc/sdf_pkg.sv ====
`default_nettype none

package sdf_pkg;
	typedef struct packed {
		logic unf_prot;
		logic ovf_prot;
		logic show_ahead;
	} sdf_ctrl_s;

	typedef struct packed {
		logic underflow_try;
		logic overflow_try;
		logic empty_hit;
		logic full_hit;
	} sdf_irq_s;

	typedef logic [31:0] sdf_word_t;
endpackage

`default_nettype wire

// ==== hw/sdf_dual_core.sv ====
`default_nettype none

module sdf_dual_core #(
	parameter int WR_WIDTH = 8,
	parameter int RD_WIDTH = 8,
	parameter int DEPTH = 16,
	parameter bit EXTRA_BIT = 1'b1,
	localparam int AW = $clog2(DEPTH),
	localparam int PW = AW + 1
) (
	input wire logic wr_clk_in,
	input wire logic wr_rst_n_in,
	input wire logic wr_req_in,
	input wire logic [WR_WIDTH-1:0] wr_data_in,
	input wire logic ovf_prot_in,
	output logic wr_full_out,
	output logic [PW-1:0] wr_used_out,
	input wire logic rd_clk_in,
	input wire logic rd_rst_n_in,
	input wire logic rd_req_in,
	input wire logic show_ahead_in,
	input wire logic unf_prot_in,
	output logic [RD_WIDTH-1:0] rd_data_out,
	output logic rd_empty_out,
	output logic [PW-1:0] rd_used_out
);
	localparam int U = (WR_WIDTH < RD_WIDTH) ? WR_WIDTH : RD_WIDTH;
	localparam int WRR = WR_WIDTH / U;
	localparam int RDR = RD_WIDTH / U;
	localparam int WSH = $clog2(WRR);
	localparam int RSH = $clog2(RDR);

	// ------------------------------------------------------------------------
	// Gray helpers
	// ------------------------------------------------------------------------
	// Pointers are shifted down by the side ratio first, so each step is one
	// Gray bit even when a wide side moves several narrow units at once.
	function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [PW-1:0] from_gray(input logic [PW-1:0] g);
		logic [PW-1:0] b;
		b = g;
		for (int i = PW - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	typedef struct packed {
		logic [DEPTH-1:0][U-1:0] mem;
		logic [PW-1:0] wr_bin;
		logic [PW-1:0] wr_gray;
		logic [PW-1:0] rd_sync1;
		logic [PW-1:0] rd_sync2;
		logic [PW-1:0] used;
		logic full;
	} sdf_wside_s;

	typedef struct packed {
		logic [PW-1:0] rd_bin;
		logic [PW-1:0] rd_gray;
		logic [PW-1:0] wr_sync1;
		logic [PW-1:0] wr_sync2;
		logic [PW-1:0] used;
		logic empty;
		logic [RD_WIDTH-1:0] data;
	} sdf_rside_s;

	sdf_wside_s w_reg, w_next;
	sdf_rside_s r_reg, r_next;
	logic wr_go;
	logic rd_go;

	// ------------------------------------------------------------------------
	// Write domain
	// ------------------------------------------------------------------------
	assign wr_go = wr_req_in && (!w_reg.full || !ovf_prot_in);

	always_comb begin
		logic [AW-1:0] idx;
		idx = '0;
		w_next = w_reg;
		if (wr_go) begin
			for (int i = 0; i < WRR; i++) begin
				idx = w_reg.wr_bin[AW-1:0] + AW'(i);
				w_next.mem[idx] = wr_data_in[i*U +: U];
			end
			w_next.wr_bin = w_reg.wr_bin + PW'(WRR);
		end
		w_next.wr_gray = to_gray(w_next.wr_bin >> WSH);
		w_next.rd_sync1 = r_reg.rd_gray;
		w_next.rd_sync2 = w_reg.rd_sync1;
		w_next.used = w_next.wr_bin - (from_gray(w_reg.rd_sync2) << RSH);
		w_next.full = w_next.used > PW'(DEPTH - WRR);
	end

	always_ff @(posedge wr_clk_in or negedge wr_rst_n_in) begin
		if (!wr_rst_n_in) begin
			w_reg <= '0;
		end else begin
			w_reg <= w_next;
		end
	end

	// ------------------------------------------------------------------------
	// Read domain
	// ------------------------------------------------------------------------
	assign rd_go = rd_req_in && (!r_reg.empty || !unf_prot_in);

	always_comb begin
		logic [AW-1:0] idx;
		logic [PW-1:0] src;
		idx = '0;
		src = '0;
		r_next = r_reg;
		if (rd_go) begin
			r_next.rd_bin = r_reg.rd_bin + PW'(RDR);
		end
		src = show_ahead_in ? r_next.rd_bin : r_reg.rd_bin;
		if (show_ahead_in || rd_go) begin
			for (int i = 0; i < RDR; i++) begin
				idx = src[AW-1:0] + AW'(i);
				r_next.data[i*U +: U] = w_reg.mem[idx];
			end
		end
		r_next.rd_gray = to_gray(r_next.rd_bin >> RSH);
		r_next.wr_sync1 = w_reg.wr_gray;
		r_next.wr_sync2 = r_reg.wr_sync1;
		r_next.used = (from_gray(r_reg.wr_sync2) << WSH) - r_next.rd_bin;
		r_next.empty = r_next.used < PW'(RDR);
	end

	always_ff @(posedge rd_clk_in or negedge rd_rst_n_in) begin
		if (!rd_rst_n_in) begin
			r_reg <= '0;
			r_reg.empty <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign wr_full_out = w_reg.full;
	assign wr_used_out = EXTRA_BIT ? w_reg.used : {1'b0, w_reg.used[AW-1:0]};
	assign rd_empty_out = r_reg.empty;
	assign rd_used_out = EXTRA_BIT ? r_reg.used : {1'b0, r_reg.used[AW-1:0]};
	assign rd_data_out = r_reg.data;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	chk_gray_one_bit: assert property (@(posedge wr_clk_in) disable iff (!wr_rst_n_in)
		$countones(w_reg.wr_gray ^ $past(w_reg.wr_gray)) <= 1)
		else $error("write pointer code moved more than one bit");

	chk_dual_unf_guard: assert property (@(posedge rd_clk_in) disable iff (!rd_rst_n_in)
		unf_prot_in && r_reg.empty && rd_req_in |=> $stable(r_reg.rd_bin))
		else $error("read pointer moved while empty and protected");
endmodule // sdf_dual_core

`default_nettype wire

// ==== testbench/sdf_user_model.sv ====
`default_nettype none

module sdf_user_model #(
	parameter int W = 8
) (
	input wire logic clk_in,
	output logic wr_req_out,
	output logic [W-1:0] wr_data_out,
	output logic rd_req_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		wr_req_out = 1'b0;
		wr_data_out = '0;
		rd_req_out = 1'b0;
	end

	// ------------------------------------------------------------------------
	// One operation cycle
	// ------------------------------------------------------------------------
	// Released data turns to the inverse of the last word, so a late sample cannot pass.
	task automatic op(input logic w, input logic [W-1:0] d, input logic r);
		@(posedge clk_in);
		wr_req_out <= w;
		wr_data_out <= d;
		rd_req_out <= r;
		@(posedge clk_in);
		wr_req_out <= 1'b0;
		wr_data_out <= ~d;
		rd_req_out <= 1'b0;
		#1;
	endtask
endmodule // sdf_user_model

`default_nettype wire

// ==== testbench/testbench.sv ====
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, rst_n, psel, penable, pwrite, pslverr, pready, irq;
	logic wr_req, rd_req, full, empty, afull, aempty;
	logic [7:0] paddr;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic [31:0] pwdata, prdata, rv;
	logic [4:0] used;
	logic d_full, d_empty;
	logic [7:0] d_rd_data;
	logic [4:0] d_wused, d_rused;
	logic err;
	int fails = 0;
	int check_count = 0;

	// ------------------------------------------------------------------------
	// Design and user logic
	// ------------------------------------------------------------------------
	// Depth is kept a power of two.
	sdf_fifo_top #(.DEPTH(16), .EXTRA_BIT(1'b1)) uut (
		.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq), .WR_REQ_IN(wr_req),
		.WR_DATA_IN(wr_data), .RD_REQ_IN(rd_req), .RD_DATA_OUT(rd_data), .FULL_OUT(full),
		.EMPTY_OUT(empty), .ALMOST_FULL_OUT(afull), .ALMOST_EMPTY_OUT(aempty),
		.USED_OUT(used), .WR_USED_OUT(), .RD_USED_OUT());

	// The dual variant shares the stimulus, so it is only compared where its flags have settled.
	sdf_fifo_top #(.DEPTH(16), .DUAL_CLOCK(1'b1), .EXTRA_BIT(1'b1)) uut_dual (
		.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(),
		.PREADY_OUT(), .PSLVERR_OUT(), .IRQ_OUT(), .WR_REQ_IN(wr_req),
		.WR_DATA_IN(wr_data), .RD_REQ_IN(rd_req), .RD_DATA_OUT(d_rd_data),
		.FULL_OUT(d_full), .EMPTY_OUT(d_empty), .ALMOST_FULL_OUT(), .ALMOST_EMPTY_OUT(),
		.USED_OUT(), .WR_USED_OUT(d_wused), .RD_USED_OUT(d_rused));

	sdf_user_model #(.W(8)) model (.clk_in(clk), .wr_req_out(wr_req),
		.wr_data_out(wr_data), .rd_req_out(rd_req));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ------------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic wrap_up;
		if (fails == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#100000;
		fails++;
		wrap_up;
	end

	// ------------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		apb(1'b0, 8'h00, 32'h0);
		chk(rv, 32'h6);
		apb(1'b0, 8'h04, 32'h0);
		chk(rv, 32'ha);
		chk({full, empty}, 2'h1);
		chk({d_full, d_empty}, 2'h1);
		for (int i = 0; i < 16; i++) model.op(1'b1, 8'h10 + i[7:0], 1'b0);
		model.op(1'b1, 8'hee, 1'b0);
		chk(used, 5'h10);
		chk({full, empty, afull, aempty}, 4'ha);
		apb(1'b0, 8'h04, 32'h0);
		chk(rv, 32'h1005);
		apb(1'b0, 8'h08, 32'h0);
		chk(rv, 32'h5);
		chk(irq, 1'b0);
		apb(1'b1, 8'h0c, 32'h4);
		chk(irq, 1'b1);
		apb(1'b1, 8'h08, 32'h4);
		chk(irq, 1'b0);
		chk({d_full, d_empty}, 2'h2);
		chk(d_wused, 5'h10);
		chk(d_rused, 5'h10);
		for (int i = 0; i < 16; i++) begin
			model.op(1'b0, 8'h0, 1'b1);
			chk(rd_data, 8'h10 + i[7:0]);
			chk(d_rd_data, 8'h10 + i[7:0]);
		end
		chk({full, empty}, 2'h1);
		chk(d_empty, 1'b1);
		model.op(1'b0, 8'h0, 1'b1);
		chk(rd_data, 8'h1f);
		chk(d_rd_data, 8'h1f);
		chk(used, 5'h0);
		chk(d_rused, 5'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk(rv, 32'hb);
		chk(d_wused, 5'h0);
		apb(1'b1, 8'h08, 32'hf);
		model.op(1'b1, 8'h21, 1'b0);
		model.op(1'b1, 8'h22, 1'b1);
		chk(rd_data, 8'h21);
		chk(used, 5'h1);
		model.op(1'b0, 8'h0, 1'b1);
		chk(rd_data, 8'h22);
		apb(1'b1, 8'h00, 32'h7);
		model.op(1'b1, 8'h31, 1'b0);
		chk(rd_data, 8'h31);
		model.op(1'b1, 8'h32, 1'b0);
		model.op(1'b0, 8'h0, 1'b1);
		chk(rd_data, 8'h32);
		model.op(1'b0, 8'h0, 1'b1);
		chk(empty, 1'b1);
		apb(1'b0, 8'h10, 32'h0);
		chk(32'(err), 32'h1);
		chk(rv, 32'h0);
		wrap_up;
	end
endmodule // testbench

`default_nettype wire
